// >>> rtl/mbs_pkg.sv
// Constants, types and helpers for the Modbus RTU register slave
package mbs_pkg;
  // ==========================================================
  // Register map
  localparam logic [15:0] REG_DISP = 16'h0001;
  localparam logic [15:0] REG_ERR = 16'h0002;
  localparam logic [15:0] REG_DP = 16'h0003;
  localparam logic [15:0] REG_ADDR = 16'h0020;
  localparam logic [15:0] REG_ID = 16'h0021;
  localparam logic [15:0] REG_BAUD = 16'h0022;
  localparam logic [15:0] REG_LOCK = 16'h0023;
  localparam logic [15:0] REG_PT_LO = 16'h0070;
  localparam logic [15:0] REG_PT_HI = 16'h0097;
  localparam logic [15:0] REG_AO_LO = 16'h00A0;
  localparam logic [15:0] REG_AO_HI = 16'h00A5;
  // ==========================================================
  // Function and exception codes
  localparam logic [7:0] FN_READ = 8'h03;
  localparam logic [7:0] FN_WR1 = 8'h06;
  localparam logic [7:0] FN_WRN = 8'h10;
  localparam logic [7:0] EX_NONE = 8'h00;
  localparam logic [7:0] EX_FUNC = 8'h01;
  localparam logic [7:0] EX_ADDR = 8'h02;
  localparam logic [7:0] EX_DATA = 8'h03;
  localparam logic [7:0] EX_LOCK = 8'h08;
  localparam logic [7:0] EX_OVER = 8'hA0;
  localparam logic [7:0] EX_UNDER = 8'h60;
  localparam logic [7:0] EX_FLAG = 8'h80;
  localparam logic [7:0] BCAST = 8'h00;
  // ==========================================================
  // Limits and reset values
  localparam logic [15:0] MAX_REGS = 16'h0010;
  localparam int BUF_DEPTH = 64;
  localparam int N_PTS = 20;
  localparam int N_AO = 6;
  localparam logic [15:0] PT_UNDEF = 16'h8000;
  localparam logic [7:0] RST_ADDR = 8'h01;
  localparam logic [15:0] BAUD_19200 = 16'h0004;
  localparam logic [15:0] RST_BAUD = 16'h0004;
  localparam logic [15:0] BAUD_MAX = 16'h0007;
  localparam logic [15:0] DP_MAX = 16'h0003;
  localparam logic [15:0] ADDR_MIN = 16'h0001;
  localparam logic [15:0] ADDR_MAX = 16'h00F7;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  // ==========================================================
  // Frame silence timing
  localparam longint CLK_HZ = 100000000;
  localparam longint T35_BAUD = 19200;
  localparam longint CHAR_BITS = 11;
  localparam longint T35_TENTHS = 35;
  localparam int T35_CYC_DEF = int'((CLK_HZ * CHAR_BITS * T35_TENTHS
    + T35_BAUD * 10 - 1) / (T35_BAUD * 10));
  localparam int SIL_W = 24;
  // ==========================================================
  // Types and helpers
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } mbs_byte_t;

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    return r;
  endfunction

  function automatic logic in_rng(input logic [15:0] a,
                                  input logic [15:0] lo,
                                  input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction
endpackage

// >>> rtl/mbs_slave.sv
// Modbus RTU slave: frame decode, register access and reply
//
// How it works
// - Only functions 03h, 06h, 10h served; others get illegal-function.
// - Exception codes: 01h function, 02h address, 03h data value.
// - Addressed write passing frame checks while remote writing is locked answers exception 08h.
// - A0h/60h only on single read of displayed value by 03h.
// - Exception reply: address, function with top bit, code, CRC.
// - Reply after slave address write still carries the old address.
// - Baud register write takes effect before its reply is sent.
// - Baud selector value 4 means 19200 baud.
// - Broadcast writes are executed, never answered; broadcast reads dropped.
// - At most 16 registers per read; byte count twice count, in order.
// - Lock may be set remotely, but cleared only by the local menu.
// - Curve point with X equal 8000h is undefined and unused.
// - Point becomes defined once both X and Y have been written.
// - Analog output registers exist only on variants with an output.
// - Single write reply echoes the request frame exactly.
// - Reg 01h returns signed display value; 03h holds decimal point.
// - Error status reads zero when no measurement error exists.
// - Reg 21h returns a fixed 16-bit identification code.
// - Words travel high byte first; CRC low byte then high byte.
`timescale 1ns/1ps
module mbs_slave #(
  parameter int T35_CYC = mbs_pkg::T35_CYC_DEF,
  // Arbitrary identification value
  parameter logic [15:0] DEV_ID = 16'h5A3C
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Serial byte stream
  input mbs_pkg::mbs_byte_t rx_i,
  output mbs_pkg::mbs_byte_t tx_o,
  input wire logic tx_ready,
  // Measurement side
  input wire logic [15:0] meas_value,
  input wire logic [15:0] meas_err,
  input wire logic over_range,
  input wire logic under_range,
  input wire logic has_aout,
  // Local menu
  input wire logic menu_unlock,
  // Settings
  output logic [7:0] slave_addr,
  output logic [15:0] baud_sel,
  output logic baud_is_19200,
  output logic [15:0] dp_pos,
  output logic remote_write_lock,
  output logic [mbs_pkg::N_PTS-1:0] point_valid
);
  typedef enum logic [2:0] {
    S_RX, S_CHECK, S_READ, S_VERIFY, S_APPLY, S_SEND
  } mbs_state_t;

  mbs_state_t state_q, state_d;
  logic [7:0] buf_q [0:mbs_pkg::BUF_DEPTH-1];
  logic [6:0] len_q, pos_q, nxt;
  logic ovf_q;
  logic [15:0] crc_q, crc_n;
  logic [7:0] tx_q;
  logic [mbs_pkg::SIL_W-1:0] sil_q;
  logic [15:0] start_q;
  logic [4:0] cnt_q, idx_q;
  logic [7:0] addr_q;
  logic [15:0] baud_q, dp_q;
  logic lock_q;
  logic [15:0] px_q [0:mbs_pkg::N_PTS-1];
  logic [15:0] py_q [0:mbs_pkg::N_PTS-1];
  logic [mbs_pkg::N_PTS-1:0] hx_q, hy_q;
  logic [15:0] ao_q [0:mbs_pkg::N_AO-1];
  logic frame_end, bcast, drop, last, tx_fire, sent;
  logic [15:0] rq_cnt, ra, wd, rd_val, pt_off, ao_off;
  logic rd_ok, pt_hit, ao_hit, len_ok, cnt_bad;
  logic [7:0] cexc, rexc, wexc, exc;
  logic [6:0] wix, rix;

  // ==========================================================
  // Frame decode
  assign bcast = buf_q[0] == mbs_pkg::BCAST;
  assign rq_cnt = {buf_q[4], buf_q[5]};
  assign cnt_bad = rq_cnt == 16'h0000 || rq_cnt > mbs_pkg::MAX_REGS;
  assign frame_end = state_q == S_RX && len_q != 7'd0 && !rx_i.valid
    && sil_q == mbs_pkg::SIL_W'(T35_CYC - 1);

  always_comb
  begin
    len_ok = 1'b1;
    cexc = mbs_pkg::EX_NONE;
    unique case (buf_q[1])
      mbs_pkg::FN_READ:
      begin
        len_ok = len_q == 7'd8;
        cexc = cnt_bad ? mbs_pkg::EX_DATA : mbs_pkg::EX_NONE;
      end
      mbs_pkg::FN_WR1:
        len_ok = len_q == 7'd8;
      mbs_pkg::FN_WRN:
      begin
        len_ok = cnt_bad || len_q == 7'd9 + {1'b0, rq_cnt[4:0], 1'b0};
        if (cnt_bad || buf_q[6] != {2'b00, rq_cnt[4:0], 1'b0})
          cexc = mbs_pkg::EX_DATA;
      end
      default:
        cexc = mbs_pkg::EX_FUNC;
    endcase
  end

  // Bad CRC, foreign address, bad length or broadcast read: silent
  assign drop = len_q < 7'd4 || ovf_q || crc_q != 16'h0000
    || !(buf_q[0] == addr_q || bcast) || !len_ok
    || (bcast && buf_q[1] != mbs_pkg::FN_WR1
        && buf_q[1] != mbs_pkg::FN_WRN);

  // ==========================================================
  // Register walk
  assign ra = start_q + {11'h000, idx_q};
  assign last = idx_q == cnt_q - 5'd1;
  assign wix = {1'b0, idx_q, 1'b0} + 7'd7;
  assign rix = {1'b0, idx_q, 1'b0} + 7'd3;
  assign wd = buf_q[1] == mbs_pkg::FN_WR1 ? {buf_q[4], buf_q[5]}
    : {buf_q[wix[5:0]], buf_q[wix[5:0] + 6'd1]};
  assign pt_off = ra - mbs_pkg::REG_PT_LO;
  assign ao_off = ra - mbs_pkg::REG_AO_LO;
  assign pt_hit = mbs_pkg::in_rng(ra, mbs_pkg::REG_PT_LO, mbs_pkg::REG_PT_HI);
  assign ao_hit = has_aout
    && mbs_pkg::in_rng(ra, mbs_pkg::REG_AO_LO, mbs_pkg::REG_AO_HI);

  always_comb
  begin
    rd_ok = 1'b1;
    rd_val = 16'h0000;
    if (ra == mbs_pkg::REG_DISP)
      rd_val = meas_value;
    else if (ra == mbs_pkg::REG_ERR)
      rd_val = meas_err;
    else if (ra == mbs_pkg::REG_DP)
      rd_val = dp_q;
    else if (ra == mbs_pkg::REG_ADDR)
      rd_val = {8'h00, addr_q};
    else if (ra == mbs_pkg::REG_ID)
      rd_val = DEV_ID;
    else if (ra == mbs_pkg::REG_BAUD)
      rd_val = baud_q;
    else if (ra == mbs_pkg::REG_LOCK)
      rd_val = {15'h0000, lock_q};
    else if (pt_hit)
      rd_val = pt_off[0] ? py_q[pt_off[5:1]] : px_q[pt_off[5:1]];
    else if (ao_hit)
      rd_val = ao_q[ao_off[2:0]];
    else
      rd_ok = 1'b0;
  end

  always_comb
  begin
    rexc = mbs_pkg::EX_NONE;
    if (!rd_ok)
      rexc = mbs_pkg::EX_ADDR;
    else if (cnt_q == 5'd1 && start_q == mbs_pkg::REG_DISP)
    begin
      if (over_range)
        rexc = mbs_pkg::EX_OVER;
      else if (under_range)
        rexc = mbs_pkg::EX_UNDER;
    end
  end

  always_comb
  begin
    wexc = mbs_pkg::EX_NONE;
    if (lock_q)
      wexc = mbs_pkg::EX_LOCK;
    else if (ra == mbs_pkg::REG_DP)
      wexc = wd > mbs_pkg::DP_MAX ? mbs_pkg::EX_DATA : mbs_pkg::EX_NONE;
    else if (ra == mbs_pkg::REG_ADDR)
      wexc = (wd < mbs_pkg::ADDR_MIN || wd > mbs_pkg::ADDR_MAX)
        ? mbs_pkg::EX_DATA : mbs_pkg::EX_NONE;
    else if (ra == mbs_pkg::REG_BAUD)
      wexc = wd > mbs_pkg::BAUD_MAX ? mbs_pkg::EX_DATA : mbs_pkg::EX_NONE;
    else if (ra == mbs_pkg::REG_LOCK)
      wexc = wd > 16'h0001 ? mbs_pkg::EX_DATA : mbs_pkg::EX_NONE;
    else if (!pt_hit && !ao_hit)
      wexc = mbs_pkg::EX_ADDR;
  end

  // ==========================================================
  // Sequencing
  assign tx_fire = state_q == S_SEND && tx_ready;
  assign sent = tx_fire && pos_q == len_q + 7'd1;

  always_comb
  begin
    state_d = state_q;
    exc = mbs_pkg::EX_NONE;
    unique case (state_q)
      S_RX:
        if (frame_end)
          state_d = S_CHECK;
      S_CHECK:
      begin
        exc = cexc;
        if (drop)
          state_d = S_RX;
        else if (exc != mbs_pkg::EX_NONE)
          state_d = bcast ? S_RX : S_SEND;
        else
          state_d = buf_q[1] == mbs_pkg::FN_READ ? S_READ : S_VERIFY;
      end
      S_READ:
      begin
        exc = rexc;
        if (exc != mbs_pkg::EX_NONE || last)
          state_d = S_SEND;
      end
      S_VERIFY:
      begin
        exc = wexc;
        if (exc != mbs_pkg::EX_NONE)
          state_d = bcast ? S_RX : S_SEND;
        else if (last)
          state_d = S_APPLY;
      end
      S_APPLY:
        if (last)
          state_d = bcast ? S_RX : S_SEND;
      S_SEND:
        if (sent)
          state_d = S_RX;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      state_q <= S_RX;
    else
      state_q <= state_d;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      start_q <= 16'h0000;
      cnt_q <= 5'd0;
      idx_q <= 5'd0;
    end
    else if (state_q == S_CHECK)
    begin
      start_q <= {buf_q[2], buf_q[3]};
      cnt_q <= buf_q[1] == mbs_pkg::FN_WR1 ? 5'd1 : rq_cnt[4:0];
      idx_q <= 5'd0;
    end
    else if (state_q == S_VERIFY && state_d == S_APPLY)
      idx_q <= 5'd0;
    else
      idx_q <= idx_q + 5'd1;
  end

  // Restarts on every byte; cleared in other states, bytes there are ignored
  always_ff @(posedge clk)
  begin
    if (sys_rst || state_q != S_RX || rx_i.valid)
      sil_q <= '0;
    else if (sil_q != mbs_pkg::SIL_W'(T35_CYC - 1))
      sil_q <= sil_q + 1'b1;
  end

  // ==========================================================
  // Frame buffer: receive, build reply, send
  assign nxt = pos_q + 7'd1;
  assign crc_n = pos_q < len_q ? mbs_pkg::crc_step(crc_q, tx_q) : crc_q;

  always_ff @(posedge clk)
  begin
    if (sys_rst || state_d == S_RX && state_q != S_RX)
    begin
      len_q <= 7'd0;
      ovf_q <= 1'b0;
      crc_q <= mbs_pkg::CRC_INIT;
      pos_q <= 7'd0;
      tx_q <= 8'h00;
    end
    else if (state_q == S_RX && rx_i.valid)
    begin
      crc_q <= mbs_pkg::crc_step(crc_q, rx_i.data);
      if (len_q < 7'(mbs_pkg::BUF_DEPTH))
      begin
        buf_q[len_q[5:0]] <= rx_i.data;
        len_q <= len_q + 7'd1;
      end
      else
        ovf_q <= 1'b1;
    end
    else if (state_q != S_SEND && state_d == S_SEND)
    begin
      crc_q <= mbs_pkg::CRC_INIT;
      pos_q <= 7'd0;
      tx_q <= buf_q[0];
      if (exc != mbs_pkg::EX_NONE)
      begin
        buf_q[1] <= buf_q[1] | mbs_pkg::EX_FLAG;
        buf_q[2] <= exc;
        len_q <= 7'd3;
      end
      else if (state_q == S_READ)
      begin
        buf_q[2] <= {2'b00, cnt_q, 1'b0};
        buf_q[rix[5:0]] <= rd_val[15:8];
        buf_q[rix[5:0] + 6'd1] <= rd_val[7:0];
        len_q <= rix + 7'd2;
      end
      else
        len_q <= 7'd6;
    end
    else if (state_q == S_READ)
    begin
      buf_q[rix[5:0]] <= rd_val[15:8];
      buf_q[rix[5:0] + 6'd1] <= rd_val[7:0];
    end
    else if (tx_fire)
    begin
      crc_q <= crc_n;
      pos_q <= nxt;
      tx_q <= nxt < len_q ? buf_q[nxt[5:0]]
        : nxt == len_q ? crc_n[7:0] : crc_n[15:8];
    end
  end

  // One driver for the whole carrier
  assign tx_o = '{valid: state_q == S_SEND, data: tx_q};

  // ==========================================================
  // Settings registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      addr_q <= mbs_pkg::RST_ADDR;
      baud_q <= mbs_pkg::RST_BAUD;
      dp_q <= 16'h0000;
      hx_q <= '0;
      hy_q <= '0;
      for (int i = 0; i < mbs_pkg::N_PTS; i++)
      begin
        px_q[i] <= mbs_pkg::PT_UNDEF;
        py_q[i] <= 16'h0000;
      end
      for (int i = 0; i < mbs_pkg::N_AO; i++)
        ao_q[i] <= 16'h0000;
    end
    else if (state_q == S_APPLY)
    begin
      if (ra == mbs_pkg::REG_DP)
        dp_q <= wd;
      else if (ra == mbs_pkg::REG_ADDR)
        addr_q <= wd[7:0];
      else if (ra == mbs_pkg::REG_BAUD)
        baud_q <= wd;
      else if (pt_hit && pt_off[0])
      begin
        py_q[pt_off[5:1]] <= wd;
        hy_q[pt_off[5:1]] <= 1'b1;
      end
      else if (pt_hit)
      begin
        px_q[pt_off[5:1]] <= wd;
        hx_q[pt_off[5:1]] <= 1'b1;
      end
      else if (ao_hit)
        ao_q[ao_off[2:0]] <= wd;
    end
  end

  // Link can only raise the lock; a raise beats a same-cycle menu clear
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      lock_q <= 1'b0;
    else if (state_q == S_APPLY && ra == mbs_pkg::REG_LOCK && wd[0])
      lock_q <= 1'b1;
    else if (menu_unlock)
      lock_q <= 1'b0;
  end

  always_comb
  begin
    for (int i = 0; i < mbs_pkg::N_PTS; i++)
      point_valid[i] = hx_q[i] && hy_q[i]
        && px_q[i] != mbs_pkg::PT_UNDEF;
  end

  assign slave_addr = addr_q;
  assign baud_sel = baud_q;
  assign baud_is_19200 = baud_q == mbs_pkg::BAUD_19200;
  assign dp_pos = dp_q;
  assign remote_write_lock = lock_q;
endmodule

// >>> test/mbs_slave_sva.sv
// Concurrent checks on the Modbus slave ports
`timescale 1ns/1ps
module mbs_slave_sva #(
  parameter int T35_CYC = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Byte stream
  input mbs_pkg::mbs_byte_t rx_i,
  input mbs_pkg::mbs_byte_t tx_o,
  input wire logic tx_ready,
  // Settings
  input wire logic menu_unlock,
  input wire logic [7:0] slave_addr,
  input wire logic [15:0] baud_sel,
  input wire logic baud_is_19200,
  input wire logic [15:0] dp_pos,
  input wire logic remote_write_lock
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Cycles since the last received byte, saturating
  logic [15:0] sil_q;
  always_ff @(posedge clk)
  begin
    if (sys_rst || rx_i.valid)
      sil_q <= 16'h0000;
    else if (sil_q != 16'hFFFF)
      sil_q <= sil_q + 16'h0001;
  end
  // ==========================================================
  // Properties
  sequence s_stall;
    tx_o.valid && !tx_ready;
  endsequence
  sequence s_hold;
    tx_o.valid && $stable(tx_o.data);
  endsequence
  property p_hold;
    s_stall |=> s_hold;
  endproperty
  a_hold: assert property (p_hold)
    else $error("reply byte changed while stalled");
  property p_baud;
    baud_is_19200 == (baud_sel == 16'h0004);
  endproperty
  a_baud: assert property (p_baud)
    else $error("baud flag disagrees with selector");
  property p_unlock;
    $fell(remote_write_lock) |-> $past(menu_unlock) || $past(sys_rst);
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("write lock cleared without menu");
  property p_lock_set;
    $rose(remote_write_lock) |-> !$past(tx_o.valid);
  endproperty
  a_lock_set: assert property (p_lock_set)
    else $error("write lock changed during a reply");
  property p_addr;
    $changed(slave_addr) |-> !$past(tx_o.valid) || $past(sys_rst);
  endproperty
  a_addr: assert property (p_addr)
    else $error("own address changed during a reply");
  property p_baud_chg;
    $changed(baud_sel) |-> !$past(tx_o.valid) || $past(sys_rst);
  endproperty
  a_baud_chg: assert property (p_baud_chg)
    else $error("baud changed after reply started");
  property p_range;
    slave_addr inside {[8'h01:8'hF7]} && baud_sel <= 16'h0007
      && dp_pos <= 16'h0003;
  endproperty
  a_range: assert property (p_range)
    else $error("setting outside its permitted range");
  property p_silence;
    $rose(tx_o.valid) |-> sil_q >= 16'(T35_CYC);
  endproperty
  a_silence: assert property (p_silence)
    else $error("reply began before frame silence");
endmodule

// >>> test/mbs_master_model.sv
// Bus master model: sends query frames, collects reply bytes
`timescale 1ns/1ps
module mbs_master_model (
  // Clock
  input wire logic clk,
  // Link to slave
  output mbs_pkg::mbs_byte_t rx_i,
  output logic tx_ready,
  input mbs_pkg::mbs_byte_t tx_o
);
  initial
  begin
    rx_i = '0;
    tx_ready = 1'b1;
  end
  // Own reflected CRC, kept apart from the design helper
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i])
    begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction
  task automatic send(input logic [7:0] q[$], input bit bad);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0000, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i])
    begin
      @(posedge clk);
      rx_i <= '{valid: 1'b1, data: q[i]};
    end
    @(posedge clk);
    // Released line must not look like the last byte
    rx_i <= '{valid: 1'b0, data: ~q[q.size()-1]};
  endtask
  // Slow mode stalls every other cycle; ends after 60 idle cycles
  task automatic recv(output logic [7:0] r[$], input bit slow);
    int idle;
    r.delete();
    idle = 0;
    while (idle < 60)
    begin
      @(posedge clk);
      if (tx_o.valid === 1'b1 && tx_ready === 1'b1)
      begin
        r.push_back(tx_o.data);
        idle = 0;
      end
      else
        idle++;
      tx_ready <= slow ? ~tx_ready : 1'b1;
    end
  endtask
endmodule

// >>> test/test_mbs_slave.sv
// Self-checking bench for the Modbus RTU register slave
`timescale 1ns/1ps
module test_mbs_slave;
  localparam int T35 = 20;
  // Arbitrary identification value
  localparam logic [15:0] ID = 16'h1234;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  mbs_pkg::mbs_byte_t rx_i;
  mbs_pkg::mbs_byte_t tx_o;
  logic tx_ready;
  logic [15:0] meas_value = 16'h00FF;
  logic [15:0] meas_err = 16'h0000;
  logic over_range = 1'b0;
  logic under_range = 1'b0;
  logic has_aout = 1'b0;
  logic menu_unlock = 1'b0;
  logic [7:0] slave_addr;
  logic [15:0] baud_sel;
  logic [15:0] dp_pos;
  logic baud_is_19200;
  logic remote_write_lock;
  logic [mbs_pkg::N_PTS-1:0] point_valid;
  logic [7:0] fn [6] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h0F, 8'h2B};
  int miscompares = 0;
  int num_checks = 0;
  mbs_slave #(.T35_CYC(T35), .DEV_ID(ID)) i_dut (.clk(clk),
    .sys_rst(sys_rst), .rx_i(rx_i), .tx_o(tx_o), .tx_ready(tx_ready),
    .meas_value(meas_value), .meas_err(meas_err), .over_range(over_range),
    .under_range(under_range), .has_aout(has_aout),
    .menu_unlock(menu_unlock), .slave_addr(slave_addr),
    .baud_sel(baud_sel), .baud_is_19200(baud_is_19200), .dp_pos(dp_pos),
    .remote_write_lock(remote_write_lock), .point_valid(point_valid));
  mbs_master_model i_mst (.clk(clk), .rx_i(rx_i), .tx_ready(tx_ready),
    .tx_o(tx_o));
  initial
  begin
    forever #5 clk = ~clk;
  end
  // ==========================================================
  // Checking helpers
  task automatic cmp(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Frames given high byte first; CRC appended to both sides
  task automatic chk(input string name, input logic [95:0] rq,
                     input int nr, input logic [95:0] ex, input int ne,
                     input bit slow = 1'b0, input bit bad = 1'b0);
    logic [7:0] q[$];
    logic [7:0] e[$];
    logic [7:0] got[$];
    logic [15:0] c;
    for (int i = nr - 1; i >= 0; i--)
      q.push_back(rq[8*i +: 8]);
    for (int i = ne - 1; i >= 0; i--)
      e.push_back(ex[8*i +: 8]);
    c = i_mst.crc16(e);
    if (ne > 0)
    begin
      e.push_back(c[7:0]);
      e.push_back(c[15:8]);
    end
    i_mst.send(q, bad);
    i_mst.recv(got, slow);
    cmp({name, " size"}, 16'(e.size()), 16'(got.size()));
    foreach (e[i])
      if (i < got.size())
        cmp(name, {8'h00, e[i]}, {8'h00, got[i]});
    $display("Test %s done", name);
  endtask
  task automatic results();
    $display("Checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========================================================
  // Tests
  initial
  begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    cmp("crc", 16'hCAD5, i_mst.crc16({8'h01, 8'h03, 8'h00,
        8'h01, 8'h00, 8'h01}));
    chk("read display", 48'h010300010001, 6, 40'h01030200FF, 5);
    chk("read three", 48'h010300010003, 6,
        72'h01030600FF00000000, 9, 1'b1);
    chk("read id", 48'h010300210001, 6, {24'h010302, ID}, 5);
    under_range <= 1'b1;
    chk("under", 48'h010300010001, 6, 24'h018360, 3);
    chk("under pair", 48'h010300010002, 6, 56'h01030400FF0000, 7);
    over_range <= 1'b1;
    chk("over", 48'h010300010001, 6, 24'h0183A0, 3);
    over_range <= 1'b0;
    under_range <= 1'b0;
    foreach (fn[i])
      chk("bad function", {8'h01, fn[i], 32'h00010001}, 6,
          {8'h01, fn[i] | 8'h80, 8'h01}, 3);
    chk("unmapped", 48'h010300500001, 6, 24'h018302, 3);
    chk("count 17", 48'h010300010011, 6, 24'h018303, 3);
    chk("write dp", 48'h010600030002, 6, 48'h010600030002, 6);
    cmp("dp_pos", 16'h0002, dp_pos);
    chk("dp range", 48'h010600030005, 6, 24'h018603, 3);
    chk("write ro", 48'h010600010005, 6, 24'h018602, 3);
    chk("no aout", 48'h010300A00001, 6, 24'h018302, 3);
    has_aout <= 1'b1;
    chk("aout", 48'h010600A00001, 6, 48'h010600A00001, 6);
    chk("pt x", 48'h010600700010, 6, 48'h010600700010, 6);
    cmp("point 0 x only", 16'h0000, {15'h0, point_valid[0]});
    chk("pt y", 48'h010600710020, 6, 48'h010600710020, 6);
    cmp("point 0", 16'h0001, {15'h0, point_valid[0]});
    chk("pt free", 48'h010600708000, 6, 48'h010600708000, 6);
    cmp("point 0 free", 16'h0000, {15'h0, point_valid[0]});
    chk("pt pair", 88'h0110007200020400200030, 11,
        48'h011000720002, 6, 1'b1);
    cmp("point 1", 16'h0001, {15'h0, point_valid[1]});
    chk("byte count", 88'h0110007200020300200030, 11, 24'h019003, 3);
    chk("baud", 48'h010600220002, 6, 48'h010600220002, 6);
    cmp("baud_sel", 16'h0002, baud_sel);
    cmp("baud flag", 16'h0000, {15'h0, baud_is_19200});
    chk("broadcast", 48'h000600220004, 6, 0, 0);
    cmp("bcast baud", 16'h0004, baud_sel);
    cmp("bcast flag", 16'h0001, {15'h0, baud_is_19200});
    chk("bcast read", 48'h000300010001, 6, 0, 0);
    chk("bad crc", 48'h010300010001, 6, 0, 0, 1'b0, 1'b1);
    chk("new addr", 48'h010600200002, 6, 48'h010600200002, 6);
    cmp("slave_addr", 16'h0002, {8'h00, slave_addr});
    chk("old addr", 48'h010300010001, 6, 0, 0);
    chk("at new", 48'h020300010001, 6, 40'h02030200FF, 5);
    chk("lock", 48'h020600230001, 6, 48'h020600230001, 6);
    cmp("lock set", 16'h0001, {15'h0, remote_write_lock});
    chk("locked", 48'h020600030001, 6, 24'h028608, 3, 1'b1);
    chk("unlock", 48'h020600230000, 6, 24'h028608, 3);
    menu_unlock <= 1'b1;
    @(posedge clk);
    menu_unlock <= 1'b0;
    @(posedge clk);
    cmp("menu unlock", 16'h0000, {15'h0, remote_write_lock});
    chk("unlocked", 48'h020600030001, 6, 48'h020600030001, 6);
    results();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    results();
  end
endmodule
bind mbs_slave mbs_slave_sva #(.T35_CYC(T35_CYC)) i_sva (.clk(clk),
  .sys_rst(sys_rst), .rx_i(rx_i), .tx_o(tx_o), .tx_ready(tx_ready),
  .menu_unlock(menu_unlock), .slave_addr(slave_addr),
  .baud_sel(baud_sel), .baud_is_19200(baud_is_19200), .dp_pos(dp_pos),
  .remote_write_lock(remote_write_lock));
